/* File: shared/bfiu_cfg.svh */
`ifndef BFIU_CFG_SVH
`define BFIU_CFG_SVH

// Byte addresses of the register map (8-bit AXI4-Lite address).
`define BFIU_ADDR_W        8
`define BFIU_OFS_CMD       8'h00
`define BFIU_OFS_STATUS_FLAGS 8'h04
`define BFIU_OFS_INFO      8'h08
`define BFIU_OFS_GPR_BASE  8'h80

// Command word fields.
`define BFIU_CMD_OP_LSB    0
`define BFIU_CMD_OP_MSB    3
`define BFIU_CMD_REG_LSB   4
`define BFIU_CMD_REG_MSB   8
`define BFIU_CMD_SEL_LSB   9
`define BFIU_CMD_SEL_MSB   11

// Status flag positions.
`define BFIU_FLAG_C        0
`define BFIU_FLAG_Z        1
`define BFIU_FLAG_N        2
`define BFIU_FLAG_V        3
`define BFIU_FLAG_S        4
`define BFIU_FLAG_H        5
`define BFIU_FLAG_T        6
`define BFIU_FLAG_I        7

// Reset values.
`define BFIU_FLAGS_RST     8'h00
`define BFIU_GPR_RST       8'h00
`define BFIU_INFO_RST      4'h0

// Bus responses.
`define BFIU_RESP_OKAY     2'b00
`define BFIU_RESP_SLVERR   2'b10

`endif

/* File: shared/bfiu_pkg.sv */
package bfiu_pkg;

  typedef enum logic [3:0] {
    OP_NOP                     = 4'h0,
    OP_ROTATE_LEFT_CARRY       = 4'h1,
    OP_ROTATE_RIGHT_CARRY      = 4'h2,
    OP_ARITH_SHIFT_RIGHT       = 4'h3,
    OP_SWAP                    = 4'h4,
    OP_BIT_TO_TRANSFER_FLAG    = 4'h5,
    OP_TRANSFER_FLAG_TO_BIT    = 4'h6,
    OP_FLAG_SET_GENERIC        = 4'h7,
    OP_FLAG_CLEAR_GENERIC      = 4'h8,
    OP_SLEEP                   = 4'h9,
    OP_WATCHDOG_RESTART_INSTR  = 4'ha,
    OP_BREAK                   = 4'hb
  } bfiu_op_t;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_RESP = 2'b10
  } bfiu_wstate_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_RESP = 2'b10
  } bfiu_rstate_t;

endpackage

/* File: hdl/bfiu_core.sv */
// Behaviour
// RL1: Rotate left through carry: old C to bit 0, bit 7 to C; Z,C,N,V; one clock.
// RL2: Rotate right through carry: old C to bit 7, bit 0 to C; Z,C,N,V; one clock.
// RL3: Bit store copies selected source bit into T only; one clock.
// RL4: Bit load copies T into selected destination bit; flags unchanged; one clock.
// RL5: Set any of the eight status flags to 1 in one clock; code picks flag C instead of the sel field whenever wstrb[1] is 0.
// RL6: Clear any of the eight status flags to 0 in one clock; code picks flag C instead of the sel field whenever wstrb[1] is 0.
// RL7: Flag set or clear touches only its named flag and no general register.
// RL8: Sleep issues in one clock, keeps flags, and signals the sleep logic.
// RL9: Watchdog restart takes one clock, keeps flags, and signals the watchdog.
// RL10: Break is handled only by debug logic and changes no flags.
// RL11: Arithmetic shift right keeps bit 7, bit 0 to C; Z,C,N,V; one clock.
// RL12: Nibble swap exchanges register halves in one clock; flags unchanged.
`timescale 1ns/1ps
`include "bfiu_cfg.svh"

module bfiu_core
  import bfiu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        dbgEnable,
  output logic             sleepReq,
  output logic             wdtRestart,
  output logic             breakReq
);

  // Rotates and shifts share one flag rule: V is N xor C, S and H are kept.
  function automatic logic [7:0] shiftFlags(input logic [7:0] res, input logic cOut, input logic [7:0] sr);
    logic [7:0] f;
    f                = sr;
    f[`BFIU_FLAG_C]  = cOut;
    f[`BFIU_FLAG_Z]  = (res == 8'h00);
    f[`BFIU_FLAG_N]  = res[7];
    f[`BFIU_FLAG_V]  = res[7] ^ cOut;
    return f;
  endfunction
  logic [7:0]   gpr_r [32];
  logic [7:0]   statusFlags_r, statusFlags_nxt;
  logic [3:0]   lastOp_r, lastOp_nxt;
  bfiu_wstate_t ws_r, ws_nxt;
  logic         awGot_r, awGot_nxt;
  logic         wGot_r, wGot_nxt;
  logic [7:0]   awHeld_r, awHeld_nxt;
  logic [31:0]  wHeld_r, wHeld_nxt;
  logic [3:0]   sHeld_r, sHeld_nxt;
  logic         awready_r, awready_nxt;
  logic         wready_r, wready_nxt;
  logic         bvalid_r, bvalid_nxt;
  logic [1:0]   bresp_r, bresp_nxt;
  bfiu_rstate_t rs_r, rs_nxt;
  logic         arready_r, arready_nxt;
  logic         rvalid_r, rvalid_nxt;
  logic [31:0]  rdata_r, rdata_nxt;
  logic [1:0]   rresp_r, rresp_nxt;
  logic         sleepReq_r, sleepReq_nxt;
  logic         wdtRestart_r, wdtRestart_nxt;
  logic         breakReq_r, breakReq_nxt;
  logic         gprWe;
  logic [4:0]   gprIdx;
  logic [7:0]   gprData;
  logic         doWrite;
  logic [7:0]   wAddr;
  logic [31:0]  wData;
  logic [3:0]   wStrb;
  logic         awTake;
  logic         wTake;
  bfiu_op_t     op;
  logic [4:0]   opReg;
  logic [2:0]   opSel;
  logic [7:0]   opnd;
  logic [7:0]   res;

  assign awready    = awready_r;
  assign wready     = wready_r;
  assign bvalid     = bvalid_r;
  assign bresp      = bresp_r;
  assign arready    = arready_r;
  assign rvalid     = rvalid_r;
  assign rdata      = rdata_r;
  assign rresp      = rresp_r;
  assign sleepReq   = sleepReq_r;
  assign wdtRestart = wdtRestart_r;
  assign breakReq   = breakReq_r;
  // Write channel: address and data are taken in either order, the
  // access is performed in the cycle the later one arrives.
  always_comb begin
    awTake      = awvalid && awready_r;
    wTake       = wvalid && wready_r;
    wAddr       = awGot_r ? awHeld_r : awaddr;
    wData       = wGot_r ? wHeld_r : wdata;
    wStrb       = wGot_r ? sHeld_r : wstrb;
    doWrite     = (ws_r == WS_IDLE) && (awGot_r || awTake) && (wGot_r || wTake);
    ws_nxt      = ws_r;
    awGot_nxt   = awGot_r;
    wGot_nxt    = wGot_r;
    awHeld_nxt  = awTake ? awaddr : awHeld_r;
    wHeld_nxt   = wTake ? wdata : wHeld_r;
    sHeld_nxt   = wTake ? wstrb : sHeld_r;
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    case (ws_r)
      WS_IDLE: begin
        if (awTake) begin
          awGot_nxt   = 1'b1;
          awready_nxt = 1'b0;
        end
        if (wTake) begin
          wGot_nxt   = 1'b1;
          wready_nxt = 1'b0;
        end
        if (doWrite) begin
          ws_nxt      = WS_RESP;
          awGot_nxt   = 1'b0;
          wGot_nxt    = 1'b0;
          bvalid_nxt  = 1'b1;
          if (wAddr == `BFIU_OFS_CMD || wAddr == `BFIU_OFS_STATUS_FLAGS || wAddr >= `BFIU_OFS_GPR_BASE) begin
            bresp_nxt = `BFIU_RESP_OKAY;
          end else begin
            bresp_nxt = `BFIU_RESP_SLVERR;
          end
        end
      end
      WS_RESP: begin
        if (bready) begin
          ws_nxt      = WS_IDLE;
          bvalid_nxt  = 1'b0;
          awready_nxt = 1'b1;
          wready_nxt  = 1'b1;
        end
      end
      default: begin
        ws_nxt      = WS_IDLE;
        bvalid_nxt  = 1'b0;
        awready_nxt = 1'b1;
        wready_nxt  = 1'b1;
      end
    endcase
  end
  // Execution of a command word, and direct software writes.
  // A command completes in the cycle its write is performed.
  always_comb begin
    op             = bfiu_op_t'(wData[`BFIU_CMD_OP_MSB:`BFIU_CMD_OP_LSB]);
    opReg          = wData[`BFIU_CMD_REG_MSB:`BFIU_CMD_REG_LSB];
    opSel          = wStrb[1] ? wData[`BFIU_CMD_SEL_MSB:`BFIU_CMD_SEL_LSB] : 3'h0;
    opnd           = gpr_r[opReg];
    res            = opnd;
    statusFlags_nxt = statusFlags_r;
    lastOp_nxt     = lastOp_r;
    gprWe          = 1'b0;
    gprIdx         = opReg;
    gprData        = opnd;
    sleepReq_nxt   = 1'b0;
    wdtRestart_nxt = 1'b0;
    breakReq_nxt   = 1'b0;
    if (doWrite && wStrb[0]) begin
      if (wAddr == `BFIU_OFS_STATUS_FLAGS) begin
        statusFlags_nxt = wData[7:0];
      end else if (wAddr >= `BFIU_OFS_GPR_BASE) begin
        gprWe   = 1'b1;
        gprIdx  = wAddr[6:2];
        gprData = wData[7:0];
      end else if (wAddr == `BFIU_OFS_CMD) begin
        lastOp_nxt = op;
        case (op)
          // RL1: rotate left carry
          OP_ROTATE_LEFT_CARRY: begin
            res             = {opnd[6:0], statusFlags_r[`BFIU_FLAG_C]};
            statusFlags_nxt = shiftFlags(res, opnd[7], statusFlags_r);
            gprWe    = 1'b1;
          end
          // RL2: rotate right carry
          OP_ROTATE_RIGHT_CARRY: begin
            res             = {statusFlags_r[`BFIU_FLAG_C], opnd[7:1]};
            statusFlags_nxt = shiftFlags(res, opnd[0], statusFlags_r);
            gprWe    = 1'b1;
          end
          // RL11: arithmetic shift right
          OP_ARITH_SHIFT_RIGHT: begin
            res             = {opnd[7], opnd[7:1]};
            statusFlags_nxt = shiftFlags(res, opnd[0], statusFlags_r);
            gprWe    = 1'b1;
          end
          // RL12: nibble swap, flags kept
          OP_SWAP: begin
            res   = {opnd[3:0], opnd[7:4]};
            gprWe = 1'b1;
          end
          // RL3: bit into T
          OP_BIT_TO_TRANSFER_FLAG: begin
            statusFlags_nxt[`BFIU_FLAG_T] = opnd[opSel];
          end
          // RL4: T into bit
          OP_TRANSFER_FLAG_TO_BIT: begin
            res[opSel] = statusFlags_r[`BFIU_FLAG_T];
            gprWe      = 1'b1;
          end
          // RL5: flag set
          // RL7: only named flag
          OP_FLAG_SET_GENERIC: begin
            statusFlags_nxt[opSel] = 1'b1;
          end
          // RL6: flag clear
          OP_FLAG_CLEAR_GENERIC: begin
            statusFlags_nxt[opSel] = 1'b0;
          end
          // RL8: sleep hand-off
          OP_SLEEP: begin
            sleepReq_nxt = 1'b1;
          end
          // RL9: watchdog restart
          OP_WATCHDOG_RESTART_INSTR: begin
            wdtRestart_nxt = 1'b1;
          end
          // RL10: debug only break
          OP_BREAK: begin
            breakReq_nxt = dbgEnable;
          end
          default: begin
            lastOp_nxt = OP_NOP;
          end
        endcase
        gprData = res;
      end
    end
  end
  // Read channel: one read at a time, answered the cycle after it is taken.
  always_comb begin
    rs_nxt      = rs_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    case (rs_r)
      RS_IDLE: begin
        if (arvalid && arready_r) begin
          rs_nxt      = RS_RESP;
          arready_nxt = 1'b0;
          rvalid_nxt  = 1'b1;
          rresp_nxt   = `BFIU_RESP_OKAY;
          rdata_nxt   = 32'h0000_0000;
          if (araddr == `BFIU_OFS_STATUS_FLAGS) begin
            rdata_nxt[7:0] = statusFlags_r;
          end else if (araddr == `BFIU_OFS_INFO) begin
            rdata_nxt[3:0] = lastOp_r;
          end else if (araddr >= `BFIU_OFS_GPR_BASE) begin
            rdata_nxt[7:0] = gpr_r[araddr[6:2]];
          end else if (araddr != `BFIU_OFS_CMD) begin
            rresp_nxt = `BFIU_RESP_SLVERR;
          end
        end
      end
      RS_RESP: begin
        if (rready) begin
          rs_nxt      = RS_IDLE;
          rvalid_nxt  = 1'b0;
          arready_nxt = 1'b1;
        end
      end
      default: begin
        rs_nxt      = RS_IDLE;
        rvalid_nxt  = 1'b0;
        arready_nxt = 1'b1;
      end
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      ws_r         <= WS_IDLE;
      awGot_r      <= 1'b0;
      wGot_r       <= 1'b0;
      awHeld_r     <= 8'h00;
      wHeld_r      <= 32'h0000_0000;
      sHeld_r      <= 4'h0;
      awready_r    <= 1'b1;
      wready_r     <= 1'b1;
      bvalid_r     <= 1'b0;
      bresp_r      <= `BFIU_RESP_OKAY;
      rs_r         <= RS_IDLE;
      arready_r    <= 1'b1;
      rvalid_r     <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      rresp_r      <= `BFIU_RESP_OKAY;
      statusFlags_r <= `BFIU_FLAGS_RST;
      lastOp_r     <= `BFIU_INFO_RST;
      sleepReq_r   <= 1'b0;
      wdtRestart_r <= 1'b0;
      breakReq_r   <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        gpr_r[i] <= `BFIU_GPR_RST;
      end
    end else begin
      ws_r         <= ws_nxt;
      awGot_r      <= awGot_nxt;
      wGot_r       <= wGot_nxt;
      awHeld_r     <= awHeld_nxt;
      wHeld_r      <= wHeld_nxt;
      sHeld_r      <= sHeld_nxt;
      awready_r    <= awready_nxt;
      wready_r     <= wready_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rs_r         <= rs_nxt;
      arready_r    <= arready_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      statusFlags_r <= statusFlags_nxt;
      lastOp_r     <= lastOp_nxt;
      sleepReq_r   <= sleepReq_nxt;
      wdtRestart_r <= wdtRestart_nxt;
      breakReq_r   <= breakReq_nxt;
      if (gprWe) begin
        gpr_r[gprIdx] <= gprData;
      end
    end
  end

endmodule

/* File: verification/bfiu_core_asserts.sv */
`timescale 1ns/1ps
module bfiu_core_asserts (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        dbgEnable,
  input wire logic        sleepReq,
  input wire logic        wdtRestart,
  input wire logic        breakReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> bvalid) else $error("No write answer after one cycle.");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid) else $error("No read answer after one cycle.");
  a_write_closes: assert property (
    bvalid && bready |=> !bvalid && awready && wready) else $error("Write channel did not reopen.");
  a_read_closes: assert property (
    rvalid && rready |=> !rvalid && arready) else $error("Read channel did not reopen.");
  a_busy_blocks: assert property (
    bvalid |-> !awready && !wready) else $error("Write accepted while answer pending.");
  a_sleep_pulse: assert property (
    sleepReq |-> $rose(bvalid) ##1 !sleepReq) else $error("Sleep request not a single pulse.");
  a_wdt_pulse: assert property (
    wdtRestart |-> $rose(bvalid) && !sleepReq ##1 !wdtRestart) else $error("Restart not a single pulse.");
  a_break_gated: assert property (
    breakReq |-> $past(dbgEnable) && $rose(bvalid)) else $error("Break raised without debug logic.");
  a_err_zero: assert property (
    rvalid && rresp == 2'b10 |-> rdata == 32'h0) else $error("Refused read returned data.");
endmodule

bind bfiu_core bfiu_core_asserts bfiu_core_asserts_inst (
  .clock(clock), .srst(srst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .dbgEnable(dbgEnable),
  .sleepReq(sleepReq), .wdtRestart(wdtRestart), .breakReq(breakReq));

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        wvalid = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        dbgEnable = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sleepReq, wdtRestart, breakReq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  pulse;
  int          errTotal = 0;
  int          compares = 0;

  always #12.5 clock = ~clock;

  // Both answer readies stay high; the slave never sees back-pressure.
  bfiu_core bfiu_core_inst (
    .clock(clock), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .dbgEnable(dbgEnable), .sleepReq(sleepReq),
    .wdtRestart(wdtRestart), .breakReq(breakReq));

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      errTotal++;
    end
  endtask

  // Pulse outputs are captured at the edge where the write answer is seen.
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] s);
    int n;
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = w;
    q = 32'hx;
    s = 2'bx;
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (pa && w && awready === 1'b1) awvalid <= 1'b0;
      if (pa && !w && arready === 1'b1) arvalid <= 1'b0;
      if ((w ? awready : arready) === 1'b1) pa = 1'b0;
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (w && bvalid === 1'b1) begin
        s = bresp;
        pulse = {sleepReq, wdtRestart, breakReq};
        break;
      end
      if (!w && rvalid === 1'b1) begin
        s = rresp;
        q = rdata;
        break;
      end
    end
    if (n == 50) begin
      $display("ERROR bus answer expected within 50 cycles seen none");
      errTotal++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] s;
    xfer(1'b1, a, d, q, s);
    chk("bresp", 32'h0, {30'h0, s});
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic [1:0] s;
    xfer(1'b0, a, 32'h0, q, s);
    chk(nm, e, q);
    chk("rresp", 32'h0, {30'h0, s});
  endtask

  task automatic cmd(input logic [3:0] op, input logic [4:0] ix, input logic [2:0] sel);
    wr(8'h00, {20'h0, sel, ix, op});
  endtask

  task automatic shft(input logic [3:0] op, input logic [7:0] fi, vi, ve, fe);
    wr(8'h04, {24'h0, fi});
    wr(8'h94, {24'h0, vi});
    cmd(op, 5'd5, 3'd0);
    rdchk("gpr5", 8'h94, {24'h0, ve});
    rdchk("flags", 8'h04, {24'h0, fe});
  endtask

  task automatic t_reset();
    rdchk("flags", 8'h04, 32'h0);
    rdchk("gpr31", 8'hfc, 32'h0);
    rdchk("info", 8'h08, 32'h0);
  endtask

  task automatic t_shift();
    shft(4'h1, 8'h31, 8'h80, 8'h01, 8'h39);
    shft(4'h1, 8'h00, 8'h80, 8'h00, 8'h0b);
    shft(4'h2, 8'h01, 8'h02, 8'h81, 8'h0c);
    shft(4'h2, 8'h00, 8'h01, 8'h00, 8'h0b);
    shft(4'h3, 8'he0, 8'h81, 8'hc0, 8'he5);
    shft(4'h4, 8'h5a, 8'h3c, 8'hc3, 8'h5a);
    rdchk("info", 8'h08, 32'h4);
  endtask

  task automatic t_bits();
    wr(8'h8c, 32'h10);
    wr(8'h04, 32'hbf);
    cmd(4'h5, 5'd3, 3'd4);
    rdchk("flags", 8'h04, 32'hff);
    cmd(4'h5, 5'd3, 3'd3);
    rdchk("flags", 8'h04, 32'hbf);
    wr(8'h04, 32'h40);
    wr(8'h9c, 32'h00);
    cmd(4'h6, 5'd7, 3'd7);
    rdchk("gpr7", 8'h9c, 32'h80);
    rdchk("flags", 8'h04, 32'h40);
  endtask

  task automatic t_flags();
    wr(8'h88, 32'ha5);
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, 32'h00);
      cmd(4'h7, 5'd2, 3'(i));
      rdchk("set", 8'h04, 32'h1 << i);
      wr(8'h04, 32'hff);
      cmd(4'h8, 5'd2, 3'(i));
      rdchk("clear", 8'h04, 32'hff & ~(32'h1 << i));
    end
    rdchk("gpr2", 8'h88, 32'ha5);
  endtask

  task automatic t_ctrl();
    wr(8'h04, 32'h55);
    cmd(4'h9, 5'd0, 3'd0);
    chk("pulse", 32'h4, {29'h0, pulse});
    cmd(4'ha, 5'd0, 3'd0);
    chk("pulse", 32'h2, {29'h0, pulse});
    cmd(4'hb, 5'd0, 3'd0);
    chk("pulse", 32'h0, {29'h0, pulse});
    rdchk("info", 8'h08, 32'hb);
    dbgEnable <= 1'b1;
    cmd(4'hb, 5'd0, 3'd0);
    chk("pulse", 32'h1, {29'h0, pulse});
    cmd(4'h0, 5'd0, 3'd0);
    chk("pulse", 32'h0, {29'h0, pulse});
    rdchk("flags", 8'h04, 32'h55);
  endtask

  task automatic t_unmapped();
    logic [31:0] q;
    logic [1:0] s;
    xfer(1'b1, 8'h40, 32'hff, q, s);
    chk("bresp", 32'h2, {30'h0, s});
    xfer(1'b0, 8'h40, 32'h0, q, s);
    chk("rresp", 32'h2, {30'h0, s});
    chk("rdata", 32'h0, q);
    rdchk("cmd", 8'h00, 32'h0);
    cmd(4'h4, 5'd1, 3'd0);
    cmd(4'hc, 5'd1, 3'd0);
    rdchk("info", 8'h08, 32'h0);
    wr(8'h04, 32'h00);
    wstrb <= 4'he;
    wr(8'h04, 32'hff);
    rdchk("flags", 8'h04, 32'h0);
    wstrb <= 4'hd;
    cmd(4'h7, 5'd0, 3'd5);
    rdchk("flags", 8'h04, 32'h1);
    wstrb <= 4'hf;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_shift();
    t_bits();
    t_flags();
    t_ctrl();
    t_unmapped();
    tally_and_finish();
  end
endmodule
